// [hdl/fndc_cfg.svh]
`ifndef FNDC_CFG_SVH
`define FNDC_CFG_SVH
// ----------------------------------------------------------------
// field widths and fixed values
// ----------------------------------------------------------------
`define FNDC_INT_W 16
`define FNDC_PRIMARY_FRACTION_W 25
`define FNDC_AUX_W 14
`define FNDC_RCNT_W 5
`define FNDC_CP_W 4
`define FNDC_LOCK_MULT 1024
`define FNDC_BAND_STEPS 11
`define FNDC_STEP_CYCLES 16
`define FNDC_BAND_BITS 8
`define FNDC_CORE_BITS 2
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FNDC_RST_RCNT 5'h01
`define FNDC_RST_CP 4'h0
`define FNDC_RST_AUXMOD 14'h0002
`endif

// [hdl/fndc_dbuf.sv]
`timescale 1ns/1ps
`include "fndc_cfg.svh"
// active copies of double-buffered settings, loaded only on commit
module fndc_dbuf
	import fndc_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// shadow side
	fndc_set_if.dst shadow,
	input wire logic commit,
	// active side
	output logic [`FNDC_PRIMARY_FRACTION_W-1:0] act_primary_fraction,
	output logic [`FNDC_AUX_W-1:0] act_auxmod,
	output logic [`FNDC_AUX_W-1:0] act_auxfrac,
	output logic act_dbl,
	output logic act_half,
	output logic [`FNDC_RCNT_W-1:0] act_rcnt,
	output logic [`FNDC_CP_W-1:0] act_cp
);
	logic [`FNDC_PRIMARY_FRACTION_W-1:0] primary_fraction_q, primary_fraction_d;
	logic [`FNDC_AUX_W-1:0] auxmod_q, auxmod_d;
	logic [`FNDC_AUX_W-1:0] auxfrac_q, auxfrac_d;
	logic dbl_q, dbl_d;
	logic half_q, half_d;
	logic [`FNDC_RCNT_W-1:0] rcnt_q, rcnt_d;
	logic [`FNDC_CP_W-1:0] cp_q, cp_d;

	// ----------------------------------------------------------------
	// load on commit only; otherwise hold
	// ----------------------------------------------------------------
	always_comb begin
		primary_fraction_d = primary_fraction_q;
		auxmod_d = auxmod_q;
		auxfrac_d = auxfrac_q;
		dbl_d = dbl_q;
		half_d = half_q;
		rcnt_d = rcnt_q;
		cp_d = cp_q;
		if (commit) begin
			primary_fraction_d = shadow.primary_fraction;
			auxmod_d = shadow.auxiliary_modulus;
			auxfrac_d = shadow.auxiliary_fraction;
			dbl_d = shadow.doubler;
			half_d = shadow.ref_half_divide;
			rcnt_d = shadow.ref_count;
			cp_d = shadow.cp_current;
		end
	end

	// registers
	always_ff @(posedge core_clk) begin
		if (reset) begin
			primary_fraction_q <= '0;
			auxmod_q <= `FNDC_RST_AUXMOD;
			auxfrac_q <= '0;
			dbl_q <= 1'b0;
			half_q <= 1'b0;
			rcnt_q <= `FNDC_RST_RCNT;
			cp_q <= `FNDC_RST_CP;
		end else begin
			primary_fraction_q <= primary_fraction_d;
			auxmod_q <= auxmod_d;
			auxfrac_q <= auxfrac_d;
			dbl_q <= dbl_d;
			half_q <= half_d;
			rcnt_q <= rcnt_d;
			cp_q <= cp_d;
		end
	end

	assign act_primary_fraction = primary_fraction_q;
	assign act_auxmod = auxmod_q;
	assign act_auxfrac = auxfrac_q;
	assign act_dbl = dbl_q;
	assign act_half = half_q;
	assign act_rcnt = rcnt_q;
	assign act_cp = cp_q;
endmodule : fndc_dbuf

// [hdl/fndc_if.sv]
`timescale 1ns/1ps
`include "fndc_cfg.svh"
// shadow settings handed from the control top to the double buffer
interface fndc_set_if;
	logic [`FNDC_PRIMARY_FRACTION_W-1:0] primary_fraction;
	logic [`FNDC_AUX_W-1:0] auxiliary_modulus;
	logic [`FNDC_AUX_W-1:0] auxiliary_fraction;
	logic doubler;
	logic ref_half_divide;
	logic [`FNDC_RCNT_W-1:0] ref_count;
	logic [`FNDC_CP_W-1:0] cp_current;
	modport src (output primary_fraction, auxiliary_modulus, auxiliary_fraction, doubler, ref_half_divide,
		ref_count, cp_current);
	modport dst (input primary_fraction, auxiliary_modulus, auxiliary_fraction, doubler, ref_half_divide,
		ref_count, cp_current);
endinterface : fndc_set_if

// [hdl/fndc_pkg.sv]
package fndc_pkg;
	// calibration sequencer states
	typedef enum logic [1:0] {
		fndc_idle,
		fndc_settle,
		fndc_band
	} fndc_cal_state_type;
endpackage : fndc_pkg

// [hdl/fndc_top.sv]
`timescale 1ns/1ps
`include "fndc_cfg.svh"
// Overview of operation
// - mode bit 1 picks differential reference path, 0 single-ended positive pin.
// - comparator rate is ref times (1+doubler) over count times (1+half).
// - reference counter divides by any ratio 1 through 32.
// - feedback value is integer plus fractions over fixed 2^25 modulus.
// - both fractions zero means integer mode; modulators off when disabled.
// - listed settings each have a shadow copy apart from active.
// - shadow values go active only on commit write; software must commit.
// - commit with autocal enabled, from idle only, starts settle then band pick among four cores.
// - calibration forces tuning to reference voltage, clocked by comparator ticks.
// - phase detector polarity is fixed positive.
// - revision field readable; older-revision threshold writes left to software.
// - settle lasts lock timeout times 1024 plus timeout comparator cycles.
// - band pick clocked at comparator over band divider, 11 steps of 16.
module fndc_top
	import fndc_pkg::*;
#(
	parameter logic [7:0] REVISION = 8'h3C // arbitrary value
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// reference pins, from outside the clock domain
	input wire logic ref_input_pos,
	input wire logic ref_input_neg,
	// configuration
	input wire logic ref_diff_mode,
	input wire logic ref_doubler,
	input wire logic ref_half_divide,
	input wire logic [`FNDC_RCNT_W-1:0] ref_count,
	input wire logic [`FNDC_INT_W-1:0] int_part,
	input wire logic [`FNDC_PRIMARY_FRACTION_W-1:0] primary_fraction,
	input wire logic [`FNDC_AUX_W-1:0] auxiliary_fraction,
	input wire logic [`FNDC_AUX_W-1:0] auxiliary_modulus,
	input wire logic [`FNDC_CP_W-1:0] cp_current,
	input wire logic modulator_disable_int,
	input wire logic autocal_en,
	input wire logic [4:0] lock_timeout,
	input wire logic [9:0] timeout,
	input wire logic [7:0] band_div,
	// commit strobe, one cycle
	input wire logic commit_wr,
	// derived reference and divide value
	output logic phase_comparator_clk,
	output logic [`FNDC_INT_W-1:0] fb_int,
	output logic [`FNDC_PRIMARY_FRACTION_W-1:0] fb_primary_fraction,
	output logic [`FNDC_AUX_W-1:0] fb_auxfrac,
	output logic [`FNDC_AUX_W-1:0] fb_auxmod,
	output logic [`FNDC_CP_W-1:0] cp_active,
	output logic modulator_on,
	output logic int_mode,
	output logic pd_positive,
	// calibration
	output logic tuning_voltage_ref,
	output logic cal_busy,
	output logic [`FNDC_CORE_BITS-1:0] vco_core,
	output logic [`FNDC_BAND_BITS-1:0] vco_band,
	// status
	output logic [7:0] revision
);
	// ----------------------------------------------------------------
	// shadow and active settings
	// ----------------------------------------------------------------
	fndc_set_if shadow_if ();
	logic [`FNDC_PRIMARY_FRACTION_W-1:0] a_primary_fraction;
	logic [`FNDC_AUX_W-1:0] a_auxmod, a_auxfrac;
	logic a_dbl, a_half;
	logic [`FNDC_RCNT_W-1:0] a_rcnt;
	logic [`FNDC_CP_W-1:0] a_cp;

	// shadow copies are the configuration ports themselves
	assign shadow_if.primary_fraction = primary_fraction;
	assign shadow_if.auxiliary_modulus = auxiliary_modulus;
	assign shadow_if.auxiliary_fraction = auxiliary_fraction;
	assign shadow_if.doubler = ref_doubler;
	assign shadow_if.ref_half_divide = ref_half_divide;
	assign shadow_if.ref_count = ref_count;
	assign shadow_if.cp_current = cp_current;

	fndc_dbuf u_dbuf (
		.core_clk(core_clk),
		.reset(reset),
		.shadow(shadow_if),
		.commit(commit_wr),
		.act_primary_fraction(a_primary_fraction),
		.act_auxmod(a_auxmod),
		.act_auxfrac(a_auxfrac),
		.act_dbl(a_dbl),
		.act_half(a_half),
		.act_rcnt(a_rcnt),
		.act_cp(a_cp)
	);

	// ----------------------------------------------------------------
	// reference input synchronisers
	// ----------------------------------------------------------------
	logic [1:0] pos_sync_q, pos_sync_d;
	logic [1:0] neg_sync_q, neg_sync_d;
	logic ref_prev_q, ref_prev_d;

	always_comb begin
		pos_sync_d = {pos_sync_q[0], ref_input_pos};
		neg_sync_d = {neg_sync_q[0], ref_input_neg};
		// differential: legs must be opposite, else hold the last level so common-mode noise is ignored
		if (ref_diff_mode) begin
			ref_prev_d = (pos_sync_q[1] != neg_sync_q[1]) ? pos_sync_q[1] : ref_prev_q;
		end else begin
			ref_prev_d = pos_sync_q[1];
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			pos_sync_q <= 2'h0;
			neg_sync_q <= 2'h0;
			ref_prev_q <= 1'b0;
		end else begin
			pos_sync_q <= pos_sync_d;
			neg_sync_q <= neg_sync_d;
			ref_prev_q <= ref_prev_d;
		end
	end

	// ----------------------------------------------------------------
	// doubler, counter and divide-by-2 producing comparator ticks
	// ----------------------------------------------------------------
	logic ref_level, ref_rise, ref_edge, ref_tick;
	logic [`FNDC_RCNT_W-1:0] rcnt_q, rcnt_d;
	logic half_q, half_d;
	logic pc_tick;
	logic pcclk_q, pcclk_d;

	assign ref_level = ref_prev_d;
	assign ref_rise = ref_level & ~ref_prev_q;
	assign ref_edge = ref_level ^ ref_prev_q;
	// doubler counts both edges, limited by core clock sampling rate
	assign ref_tick = a_dbl ? ref_edge : ref_rise;

	// field 0 encodes ratio 32, so every value 1..32 is reachable
	always_comb begin
		rcnt_d = rcnt_q;
		half_d = half_q;
		pc_tick = 1'b0;
		if (ref_tick) begin
			// compare with >= so a smaller ratio after commit wraps at once instead of running past 31
			if (rcnt_q >= (a_rcnt - 5'h01)) begin
				rcnt_d = 5'h00;
				half_d = ~half_q;
				pc_tick = ~a_half | half_q;
			end else begin
				rcnt_d = rcnt_q + 5'h01;
			end
		end
		pcclk_d = pc_tick ? ~pcclk_q : pcclk_q;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			rcnt_q <= 5'h00;
			half_q <= 1'b0;
			pcclk_q <= 1'b0;
		end else begin
			rcnt_q <= rcnt_d;
			half_q <= half_d;
			pcclk_q <= pcclk_d;
		end
	end

	// ----------------------------------------------------------------
	// band calibration sequencer, advancing on comparator ticks
	// ----------------------------------------------------------------
	fndc_cal_state_type st_q, st_d;
	logic [15:0] cnt_q, cnt_d;
	logic [7:0] bdiv_q, bdiv_d;
	logic [3:0] step_q, step_d;
	logic [3:0] cyc_q, cyc_d;
	logic [`FNDC_CORE_BITS-1:0] core_q, core_d;
	logic [`FNDC_BAND_BITS-1:0] band_q, band_d;
	logic [15:0] settle_len;
	logic band_tick;

	assign settle_len = 16'(lock_timeout) * 16'(`FNDC_LOCK_MULT) + 16'(timeout);
	assign band_tick = pc_tick && ((bdiv_q + 8'h01) >= band_div);

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		bdiv_d = bdiv_q;
		step_d = step_q;
		cyc_d = cyc_q;
		core_d = core_q;
		band_d = band_q;
		case (st_q)
			fndc_idle: begin
				if (commit_wr && autocal_en) begin
					st_d = fndc_settle;
					cnt_d = 16'h0000;
				end
			end
			fndc_settle: begin
				if (pc_tick) begin
					if ((cnt_q + 16'h0001) >= settle_len) begin
						st_d = fndc_band;
						bdiv_d = 8'h00;
						step_d = 4'h0;
						cyc_d = 4'h0;
						core_d = '0;
						band_d = '0;
					end else begin
						cnt_d = cnt_q + 16'h0001;
					end
				end
			end
			fndc_band: begin
				if (pc_tick) begin
					bdiv_d = band_tick ? 8'h00 : bdiv_q + 8'h01;
				end
				if (band_tick) begin
					cyc_d = cyc_q + 4'h1;
					if (cyc_q == 4'(`FNDC_STEP_CYCLES - 1)) begin
						// binary search: first two steps pick core, next eight band bits, last step sets none
						if (step_q < 4'h2) begin
							core_d = core_q | 2'(2'h2 >> step_q);
						end else if (step_q < 4'hA) begin
							band_d = band_q | 8'(8'h80 >> (step_q - 4'h2));
						end
						step_d = step_q + 4'h1;
						if (step_q == 4'(`FNDC_BAND_STEPS - 1)) begin
							st_d = fndc_idle;
						end
					end
				end
			end
			default: st_d = fndc_idle;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			st_q <= fndc_idle;
			cnt_q <= 16'h0000;
			bdiv_q <= 8'h00;
			step_q <= 4'h0;
			cyc_q <= 4'h0;
			core_q <= 2'h0;
			band_q <= 8'h00;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			bdiv_q <= bdiv_d;
			step_q <= step_d;
			cyc_q <= cyc_d;
			core_q <= core_d;
			band_q <= band_d;
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	logic int_mode_d, busy_d;
	assign int_mode_d = (a_primary_fraction == '0) && (a_auxfrac == '0);
	assign busy_d = (st_d != fndc_idle);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			phase_comparator_clk <= 1'b0;
			fb_int <= '0;
			fb_primary_fraction <= '0;
			fb_auxfrac <= '0;
			fb_auxmod <= `FNDC_RST_AUXMOD;
			cp_active <= `FNDC_RST_CP;
			modulator_on <= 1'b0;
			int_mode <= 1'b1;
			pd_positive <= 1'b1;
			tuning_voltage_ref <= 1'b0;
			cal_busy <= 1'b0;
			vco_core <= 2'h0;
			vco_band <= 8'h00;
			revision <= 8'h00;
		end else begin
			phase_comparator_clk <= pcclk_d;
			fb_int <= int_part;
			fb_primary_fraction <= a_primary_fraction;
			fb_auxfrac <= a_auxfrac;
			fb_auxmod <= a_auxmod;
			cp_active <= a_cp;
			modulator_on <= ~(int_mode_d & modulator_disable_int);
			int_mode <= int_mode_d;
			pd_positive <= 1'b1;
			tuning_voltage_ref <= busy_d;
			cal_busy <= busy_d;
			vco_core <= core_d;
			vco_band <= band_d;
			revision <= REVISION;
		end
	end
endmodule : fndc_top

// [sim/fndc_top_asserts.sv]
`timescale 1ns/1ps
`include "fndc_cfg.svh"
// ----------------------------------------------------------------
// port checker for the divider control top
// ----------------------------------------------------------------
module fndc_top_asserts
	import fndc_pkg::*;
#(
	parameter logic [7:0] REVISION = 8'h3C // arbitrary value
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// watched inputs
	input wire logic commit_wr,
	input wire logic autocal_en,
	input wire logic modulator_disable_int,
	// watched outputs
	input wire logic [`FNDC_PRIMARY_FRACTION_W-1:0] fb_primary_fraction,
	input wire logic [`FNDC_AUX_W-1:0] fb_auxfrac,
	input wire logic [`FNDC_AUX_W-1:0] fb_auxmod,
	input wire logic [`FNDC_CP_W-1:0] cp_active,
	input wire logic modulator_on,
	input wire logic int_mode,
	input wire logic pd_positive,
	input wire logic tuning_voltage_ref,
	input wire logic cal_busy,
	input wire logic [7:0] revision
);
	// one domain, so one clock and one disable for all
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	property p_pd_fixed; pd_positive == 1'b1; endproperty
	a_pd_fixed: assert property (p_pd_fixed)
		else $error("detector polarity not positive");
	// active copies move only in the two edges after a commit
	property p_frac_hold; $changed(fb_primary_fraction) |-> $past(commit_wr) || $past(commit_wr, 2); endproperty
	a_frac_hold: assert property (p_frac_hold)
		else $error("primary fraction moved without commit");
	property p_cp_hold; $changed(cp_active) |-> $past(commit_wr) || $past(commit_wr, 2); endproperty
	a_cp_hold: assert property (p_cp_hold)
		else $error("pump current moved without commit");
	property p_aux_hold;
		$changed(fb_auxmod) || $changed(fb_auxfrac) |-> $past(commit_wr) || $past(commit_wr, 2);
	endproperty
	a_aux_hold: assert property (p_aux_hold)
		else $error("auxiliary value moved without commit");
	property p_int_mode; int_mode == (fb_primary_fraction == 25'h0000000 && fb_auxfrac == 14'h0000); endproperty
	a_int_mode: assert property (p_int_mode)
		else $error("integer mode flag disagrees with fractions");
	// settled inputs only, the flag is registered
	property p_mod_off;
		int_mode && $past(int_mode) && modulator_disable_int && $past(modulator_disable_int) |-> !modulator_on;
	endproperty
	a_mod_off: assert property (p_mod_off)
		else $error("modulator left on in integer mode");
	property p_cal_start; $rose(cal_busy) |-> $past(commit_wr && autocal_en); endproperty
	a_cal_start: assert property (p_cal_start)
		else $error("calibration started without commit");
	property p_tune_ref; tuning_voltage_ref == cal_busy; endproperty
	a_tune_ref: assert property (p_tune_ref)
		else $error("tuning switch not tied to calibration");
	// band search alone needs 176 slow ticks
	property p_cal_min; $rose(cal_busy) |-> cal_busy [*8]; endproperty
	a_cal_min: assert property (p_cal_min)
		else $error("calibration ended too early");
	property p_rev; !$past(reset) && !$past(reset, 2) |-> revision == REVISION; endproperty
	a_rev: assert property (p_rev)
		else $error("revision field wrong");
endmodule : fndc_top_asserts

bind fndc_top fndc_top_asserts #(.REVISION(REVISION)) u_chk (.core_clk, .reset, .commit_wr, .autocal_en,
	.modulator_disable_int, .fb_primary_fraction, .fb_auxfrac, .fb_auxmod, .cp_active, .modulator_on, .int_mode,
	.pd_positive, .tuning_voltage_ref, .cal_busy, .revision);

// [sim/fndc_top_tb_top.sv]
`timescale 1ns/1ps
`include "fndc_cfg.svh"
module fndc_top_tb_top;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic core_clk = 0, reset = 1, ref_input_pos = 0, ref_input_neg = 0, ref_diff_mode = 0;
	logic ref_doubler = 0, ref_half_divide = 0, modulator_disable_int = 0, autocal_en = 0, commit_wr = 0;
	logic [4:0] ref_count = 5'h01, lock_timeout = 5'h00;
	logic [15:0] int_part = 16'h0000;
	logic [24:0] primary_fraction = 25'h0000000;
	logic [13:0] auxiliary_fraction = 14'h0000, auxiliary_modulus = 14'h0002;
	logic [3:0] cp_current = 4'h0;
	logic [9:0] timeout = 10'h000;
	logic [7:0] band_div = 8'h01;
	logic phase_comparator_clk, modulator_on, int_mode, pd_positive, tuning_voltage_ref, cal_busy, pcc_q;
	logic [15:0] fb_int;
	logic [24:0] fb_primary_fraction;
	logic [13:0] fb_auxfrac, fb_auxmod;
	logic [3:0] cp_active;
	logic [1:0] vco_core, ref_sel = 2'h1, div_q = 2'h0;
	logic [7:0] vco_band, revision;
	int num_errors = 0, total_checks = 0, cyc = 0, ticks = 0;

	fndc_top uut (.core_clk, .reset, .ref_input_pos, .ref_input_neg, .ref_diff_mode, .ref_doubler,
		.ref_half_divide, .ref_count, .int_part, .primary_fraction, .auxiliary_fraction, .auxiliary_modulus,
		.cp_current, .modulator_disable_int, .autocal_en, .lock_timeout, .timeout, .band_div, .commit_wr,
		.phase_comparator_clk, .fb_int, .fb_primary_fraction, .fb_auxfrac, .fb_auxmod, .cp_active, .modulator_on,
		.int_mode, .pd_positive, .tuning_voltage_ref, .cal_busy, .vco_core, .vco_band, .revision);

	initial forever #20 core_clk = ~core_clk;
	// reference of 4 core cycles, slow enough for the pin synchroniser
	always @(posedge core_clk) begin
		div_q <= div_q + 2'h1;
		if (div_q[0]) begin
			if (ref_sel == 2'h1 || ref_sel == 2'h2) ref_input_pos <= ~ref_input_pos;
			if (ref_sel >= 2'h2) ref_input_neg <= (ref_sel == 2'h2) ? ref_input_pos : ~ref_input_neg;
		end
	end
	// comparator tick counter and hang guard
	always @(posedge core_clk) begin
		pcc_q <= phase_comparator_clk;
		if (phase_comparator_clk !== pcc_q) ticks <= ticks + 1;
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			num_errors = num_errors + 1;
			wrap_up();
		end
	end
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			$display("wrong value %s expected %0h seen %0h", name, exp, got);
			num_errors++;
		end
	endtask : check_val
	// tick counts carry two ticks of phase slop
	task automatic check_near(input string name, input int exp, input int got);
		total_checks++;
		if (got > exp + 2 || got < exp - 2) begin
			$display("wrong value %s expected %0d seen %0d", name, exp, got);
			num_errors++;
		end
	endtask : check_near
	task automatic commit();
		@(posedge core_clk) commit_wr <= 1'b1;
		@(posedge core_clk) commit_wr <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
	endtask : commit
	task automatic count_ticks(input int n, output int got);
		int t0;
		t0 = ticks;
		repeat (n) @(posedge core_clk);
		got = ticks - t0;
	endtask : count_ticks
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		repeat (3) @(posedge core_clk);
		#1;
		check_val("auxmod", 14'h0002, fb_auxmod);
		check_val("int_mode", 1'b1, int_mode);
		check_val("polarity", 1'b1, pd_positive);
		check_val("revision", 8'h3C, revision);
	endtask : t_reset
	task automatic t_buffer();
		@(posedge core_clk);
		int_part <= 16'h0044;
		auxiliary_fraction <= 14'h0200;
		auxiliary_modulus <= 14'h0600;
		cp_current <= 4'h9;
		repeat (3) @(posedge core_clk) primary_fraction <= primary_fraction + 25'h18D5A55;
		repeat (2) @(posedge core_clk);
		#1;
		check_val("primary_fraction held", 25'h0, fb_primary_fraction);
		check_val("cp held", 4'h0, cp_active);
		check_val("int live", 16'h0044, fb_int);
		commit();
		check_val("primary_fraction", 25'h0A80EFF, fb_primary_fraction);
		check_val("auxfrac", 14'h0200, fb_auxfrac);
		check_val("auxmod", 14'h0600, fb_auxmod);
		check_val("cp", 4'h9, cp_active);
		check_val("mod on", 1'b1, modulator_on);
	endtask : t_buffer
	task automatic t_intmode();
		@(posedge core_clk);
		primary_fraction <= 25'h0;
		auxiliary_fraction <= 14'h0;
		modulator_disable_int <= 1'b1;
		commit();
		@(posedge core_clk);
		#1;
		check_val("int_mode", 1'b1, int_mode);
		check_val("mod off", 1'b0, modulator_on);
		@(posedge core_clk) modulator_disable_int <= 1'b0;
	endtask : t_intmode
	task automatic t_refdiv();
		int rc_t[4] = '{1, 0, 5, 3};
		int d_t[4] = '{0, 0, 0, 1};
		int h_t[4] = '{0, 0, 1, 0};
		int e_t[4] = '{192, 6, 19, 128};
		int n;
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			ref_count <= 5'(rc_t[i]);
			ref_doubler <= 1'(d_t[i]);
			ref_half_divide <= 1'(h_t[i]);
			commit();
			repeat (8) @(posedge core_clk);
			count_ticks(768, n);
			check_near("pfd ticks", e_t[i], n);
		end
	endtask : t_refdiv
	task automatic t_refmode();
		int n;
		@(posedge core_clk);
		ref_count <= 5'h01;
		ref_doubler <= 1'b0;
		ref_sel <= 2'h3;
		commit();
		count_ticks(400, n);
		check_near("single neg only", 0, n);
		ref_diff_mode <= 1'b1;
		ref_sel <= 2'h2;
		repeat (8) @(posedge core_clk);
		count_ticks(400, n);
		check_near("diff ticks", 100, n);
		ref_diff_mode <= 1'b0;
		ref_sel <= 2'h1;
	endtask : t_refmode
	task automatic t_cal();
		int lt_t[2] = '{1, 0};
		int to_t[2] = '{0, 4};
		int bd_t[2] = '{1, 2};
		int e_t[2] = '{1200, 356};
		int t0;
		for (int i = 0; i < 2; i++) begin
			@(posedge core_clk);
			autocal_en <= 1'b1;
			lock_timeout <= 5'(lt_t[i]);
			timeout <= 10'(to_t[i]);
			band_div <= 8'(bd_t[i]);
			@(posedge core_clk) commit_wr <= 1'b1;
			@(posedge core_clk) commit_wr <= 1'b0;
			t0 = ticks;
			#1;
			check_val("busy", 1'b1, cal_busy);
			check_val("tune ref", 1'b1, tuning_voltage_ref);
			// commit while busy loads values but must not restart the search
			if (i == 1) begin
				@(posedge core_clk) cp_current <= 4'h5;
				commit();
				check_val("cp in cal", 4'h5, cp_active);
			end
			for (int k = 0; k < 8000 && cal_busy === 1'b1; k++) @(posedge core_clk);
			#1;
			check_near("cal ticks", e_t[i], ticks - t0);
			check_val("core", 2'h3, vco_core);
			check_val("band", 8'hFF, vco_band);
			check_val("tune free", 1'b0, tuning_voltage_ref);
		end
	endtask : t_cal
	task automatic wrap_up();
		$display("errors %0d checks %0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : wrap_up
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		t_reset();
		t_buffer();
		t_intmode();
		t_refdiv();
		t_refmode();
		t_cal();
		wrap_up();
	end
endmodule : fndc_top_tb_top
